// ===== rtl/pcr_cfg_regs.sv
// configuration capability registers: product data, indirect, msi, aer
`timescale 1ns/1ps
//
// Summary of operation
// - data register shows eeprom at address plus 40h
// - lowest byte lane holds byte at address
// - data register accesses honour byte enables
// - index register: 12 writable bits, rest zero
// - window access forwards to indexed internal register
// - message capability id 05h at f0h
// - message capability next pointer is 00h
// - enable bit selects messages or legacy pin
// - count fields encode 1 to 32, reserved codes
// - capable count field reads 000
// - bit 23 reads one, top byte zero
// - lower address bits 31:2 writable, 1:0 zero
// - upper address fully writable, resets zero
// - message data 16 bits, upper half zero
// - error capability id 0001h at 100h
// - error capability version reads 1h
// - error capability next offset reads 150h
// - flag write starts eeprom read or write
// - product-data capability points to f0h
module pcr_cfg_regs (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic cfg_req_i,
  input wire pcr_pkg::pcr_cfg_req_s cfg_i,
  output logic cfg_ack_o,
  output logic [31:0] cfg_rdata_o,
  input wire logic irq_i,
  output logic intx_o,
  output logic msg_vld_o,
  output pcr_pkg::pcr_msg_s msg_o,
  input wire logic msg_ack_i,
  output logic ee_req_o,
  output pcr_pkg::pcr_ee_req_s ee_cmd_o,
  input wire logic ee_ack_i,
  input wire logic [31:0] ee_rdata_i
);

  //////////////////////////////////////////////////////////////////////////
  // state
  logic [pcr_pkg::VPD_ADDR_W-1:0] vpd_addr_q;
  logic vpd_flag_q;
  logic [31:0] product_data_word_q;
  logic [pcr_pkg::IDX_W-1:0] idx_q;
  logic msi_en_q;
  logic [2:0] msi_mme_q;
  logic [31:pcr_pkg::MSI_ALO_LSB] msi_alo_q;
  logic [31:0] msi_ahi_q;
  logic [pcr_pkg::MSI_DAT_W-1:0] msi_dat_q;
  logic irq_q;

  logic [11:0] dw_addr;
  logic [11:0] eff_addr;
  logic via_win;
  logic win_loop;
  logic wr_en;
  logic [31:0] wd;
  logic [3:0] be;
  logic ee_busy;
  logic ee_done;
  logic [31:0] ee_rdata;
  logic ee_start;
  logic ee_op_we;
  pcr_pkg::pcr_ee_req_s ee_cmd;
  logic irq_rise;
  logic [31:0] rd_word;
  logic [pcr_pkg::VPD_ADDR_W-1:0] vpd_addr_d;
  logic [31:0] alo_next;
  logic [31:0] dat_next;

  //////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0] en);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (en[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic hit(input logic [11:0] off);
    return wr_en && (eff_addr == off);
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // address decode and window forwarding
  assign dw_addr = {cfg_i.addr[11:2], 2'b00};
  assign via_win = (dw_addr == pcr_pkg::OFF_WIN);
  assign eff_addr = via_win ? {idx_q[11:2], 2'b00} : dw_addr;
  // window pointing at itself reads zero and drops writes
  assign win_loop = via_win && (eff_addr == pcr_pkg::OFF_WIN);
  assign wr_en = ce_i && cfg_req_i && cfg_i.wr && !win_loop;
  assign wd = cfg_i.wdata;
  assign be = cfg_i.be;

  //////////////////////////////////////////////////////////////////////////
  // read map
  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (eff_addr)
      pcr_pkg::OFF_VPD_CTL: begin
        rd_word[7:0] = pcr_pkg::VPD_CAP_ID;
        rd_word[15:8] = pcr_pkg::VPD_NEXT;
        rd_word[pcr_pkg::VPD_ADDR_LSB +: pcr_pkg::VPD_ADDR_W] = vpd_addr_q;
        rd_word[pcr_pkg::VPD_FLAG_BIT] = vpd_flag_q;
      end
      pcr_pkg::OFF_PRODUCT_DATA_WORD: begin
        rd_word = product_data_word_q;
      end
      pcr_pkg::OFF_IDX: begin
        rd_word[pcr_pkg::IDX_W-1:0] = idx_q;
      end
      pcr_pkg::OFF_MSI_CTL: begin
        rd_word[7:0] = pcr_pkg::MSI_CAP_ID;
        rd_word[15:8] = pcr_pkg::MSI_NEXT;
        rd_word[pcr_pkg::MSI_EN_BIT] = msi_en_q;
        rd_word[pcr_pkg::MSI_MMC_LSB +: 3] = pcr_pkg::MSI_MMC_VAL;
        rd_word[pcr_pkg::MSI_MME_LSB +: 3] = msi_mme_q;
        rd_word[pcr_pkg::MSI_64_BIT] = 1'b1;
      end
      pcr_pkg::OFF_MSI_ALO: begin
        rd_word[31:pcr_pkg::MSI_ALO_LSB] = msi_alo_q;
      end
      pcr_pkg::OFF_MSI_AHI: begin
        rd_word = msi_ahi_q;
      end
      pcr_pkg::OFF_MSI_DAT: begin
        rd_word[pcr_pkg::MSI_DAT_W-1:0] = msi_dat_q;
      end
      pcr_pkg::OFF_AER_HDR: begin
        rd_word[15:0] = pcr_pkg::AER_ID;
        rd_word[19:16] = pcr_pkg::AER_VER;
        rd_word[31:20] = pcr_pkg::AER_NEXT;
      end
      default: begin
        rd_word = 32'h0000_0000;
      end
    endcase
    if (win_loop) begin
      rd_word = 32'h0000_0000;
    end
  end

  // completion: one cycle after the request, lanes not enabled read zero
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cfg_ack_o <= 1'b0;
      cfg_rdata_o <= pcr_pkg::RST_WORD;
    end else if (ce_i) begin
      cfg_ack_o <= cfg_req_i;
      if (cfg_req_i && !cfg_i.wr) begin
        cfg_rdata_o <= merge(32'h0000_0000, rd_word, be);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // product-data control: address and operation flag
  assign ee_start = hit(pcr_pkg::OFF_VPD_CTL) && be[3] && !ee_busy;
  assign ee_op_we = wd[pcr_pkg::VPD_FLAG_BIT];

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      vpd_addr_q <= '0;
    end else if (hit(pcr_pkg::OFF_VPD_CTL) && be[2] && !ee_busy) begin
      vpd_addr_q <= wd[pcr_pkg::VPD_ADDR_LSB +: pcr_pkg::VPD_ADDR_W];
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      vpd_flag_q <= 1'b0;
    end else if (ce_i) begin
      if (ee_done) begin
        vpd_flag_q <= !ee_cmd_o.we;
      end else if (ee_start) begin
        vpd_flag_q <= ee_op_we;
      end
    end
  end

  // a start may carry its own address in the same write
  assign vpd_addr_d = be[2] ?
                      wd[pcr_pkg::VPD_ADDR_LSB +: pcr_pkg::VPD_ADDR_W] :
                      vpd_addr_q;

  // eeprom byte address: dword address times four plus fixed base
  always_comb begin
    ee_cmd.we = ee_op_we;
    ee_cmd.addr = 8'({vpd_addr_d, 2'b00} + pcr_pkg::EE_BASE);
    ee_cmd.wdata = product_data_word_q;
  end

  // data register: host byte writes, eeprom reads land lane for lane
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      product_data_word_q <= pcr_pkg::RST_WORD;
    end else if (ce_i) begin
      if (ee_done && !ee_cmd_o.we) begin
        product_data_word_q <= ee_rdata;
      end else if (hit(pcr_pkg::OFF_PRODUCT_DATA_WORD)) begin
        product_data_word_q <= merge(product_data_word_q, wd, be);
      end
    end
  end

  pcr_ee_engine u_ee (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .start_i(ee_start),
    .cmd_i(ee_cmd),
    .busy_o(ee_busy),
    .done_o(ee_done),
    .rdata_o(ee_rdata),
    .ee_req_o(ee_req_o),
    .ee_cmd_o(ee_cmd_o),
    .ee_ack_i(ee_ack_i),
    .ee_rdata_i(ee_rdata_i)
  );

  //////////////////////////////////////////////////////////////////////////
  // indirect index register
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      idx_q <= pcr_pkg::IDX_RST;
    end else if (hit(pcr_pkg::OFF_IDX)) begin
      if (be[0]) begin
        idx_q[7:0] <= wd[7:0];
      end
      if (be[1]) begin
        idx_q[11:8] <= wd[11:8];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // message interrupt control; fixed fields are never stored
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      msi_en_q <= 1'b0;
      msi_mme_q <= pcr_pkg::MSI_MME_RST;
    end else if (hit(pcr_pkg::OFF_MSI_CTL) && be[2]) begin
      msi_en_q <= wd[pcr_pkg::MSI_EN_BIT];
      // reserved count codes are refused, old value kept
      if (wd[pcr_pkg::MSI_MME_LSB +: 3] <= pcr_pkg::MSI_MME_MAX) begin
        msi_mme_q <= wd[pcr_pkg::MSI_MME_LSB +: 3];
      end
    end
  end

  assign alo_next = merge({msi_alo_q, 2'b00}, wd, be);

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      msi_alo_q <= '0;
    end else if (hit(pcr_pkg::OFF_MSI_ALO)) begin
      msi_alo_q <= alo_next[31:2];
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      msi_ahi_q <= pcr_pkg::RST_WORD;
    end else if (hit(pcr_pkg::OFF_MSI_AHI)) begin
      msi_ahi_q <= merge(msi_ahi_q, wd, be);
    end
  end

  assign dat_next = merge({16'h0000, msi_dat_q}, wd, be);

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      msi_dat_q <= '0;
    end else if (hit(pcr_pkg::OFF_MSI_DAT)) begin
      msi_dat_q <= dat_next[15:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // interrupt delivery
  assign irq_rise = irq_i && !irq_q;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_q <= 1'b0;
      intx_o <= 1'b0;
    end else if (ce_i) begin
      irq_q <= irq_i;
      intx_o <= irq_i && !msi_en_q;
    end
  end

  // new event in the ack cycle starts another message
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      msg_vld_o <= 1'b0;
    end else if (ce_i) begin
      msg_vld_o <= (msg_vld_o && !msg_ack_i) || (irq_rise && msi_en_q);
    end
  end

  // destination and payload captured when a message is launched
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      msg_o <= '0;
    end else if (ce_i && irq_rise && msi_en_q &&
                 (!msg_vld_o || msg_ack_i)) begin
      msg_o.addr <= {msi_ahi_q, msi_alo_q, 2'b00};
      msg_o.data <= msi_dat_q;
    end
  end

endmodule

// ===== rtl/pcr_ee_engine.sv
// eeprom access engine: one dword read or write per start
`timescale 1ns/1ps
module pcr_ee_engine (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic start_i,
  input wire pcr_pkg::pcr_ee_req_s cmd_i,
  output logic busy_o,
  output logic done_o,
  output logic [31:0] rdata_o,
  output logic ee_req_o,
  output pcr_pkg::pcr_ee_req_s ee_cmd_o,
  input wire logic ee_ack_i,
  input wire logic [31:0] ee_rdata_i
);

  pcr_pkg::pcr_ee_state_e state_q;

  assign busy_o = (state_q != pcr_pkg::EE_IDLE);
  assign ee_req_o = (state_q == pcr_pkg::EE_WAIT);

  //////////////////////////////////////////////////////////////////////////
  // sequencing
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q <= pcr_pkg::EE_IDLE;
    end else if (ce_i) begin
      unique case (state_q)
        pcr_pkg::EE_IDLE: begin
          if (start_i) begin
            state_q <= pcr_pkg::EE_WAIT;
          end
        end
        pcr_pkg::EE_WAIT: begin
          if (ee_ack_i) begin
            state_q <= pcr_pkg::EE_IDLE;
          end
        end
      endcase
    end
  end

  // command latched at start, held until acknowledged
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ee_cmd_o <= '0;
    end else if (ce_i && start_i && !busy_o) begin
      ee_cmd_o <= cmd_i;
    end
  end

  // completion pulse and read data
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      done_o <= 1'b0;
      rdata_o <= pcr_pkg::RST_WORD;
    end else if (ce_i) begin
      done_o <= ee_req_o && ee_ack_i;
      if (ee_req_o && ee_ack_i && !ee_cmd_o.we) begin
        rdata_o <= ee_rdata_i;
      end
    end
  end

endmodule

// ===== shared/pcr_pkg.sv
// constants and carrier types for the config capability register block
package pcr_pkg;

  // register offsets (byte addresses in config space)
  localparam logic [11:0] OFF_VPD_CTL = 12'h0d8;
  localparam logic [11:0] OFF_PRODUCT_DATA_WORD = 12'h0dc;
  localparam logic [11:0] OFF_IDX = 12'h0e0;
  localparam logic [11:0] OFF_WIN = 12'h0e4;
  localparam logic [11:0] OFF_MSI_CTL = 12'h0f0;
  localparam logic [11:0] OFF_MSI_ALO = 12'h0f4;
  localparam logic [11:0] OFF_MSI_AHI = 12'h0f8;
  localparam logic [11:0] OFF_MSI_DAT = 12'h0fc;
  localparam logic [11:0] OFF_AER_HDR = 12'h100;

  // product-data capability header and control
  localparam logic [7:0] VPD_CAP_ID = 8'h03;
  localparam logic [7:0] VPD_NEXT = 8'hf0;
  localparam int VPD_ADDR_LSB = 18;
  localparam int VPD_ADDR_W = 6;
  localparam int VPD_FLAG_BIT = 31;
  localparam logic [7:0] EE_BASE = 8'h40;

  // indirect index fields
  localparam int IDX_W = 12;
  localparam logic [11:0] IDX_RST = 12'h000;

  // message interrupt capability
  localparam logic [7:0] MSI_CAP_ID = 8'h05;
  localparam logic [7:0] MSI_NEXT = 8'h00;
  localparam int MSI_EN_BIT = 16;
  localparam int MSI_MMC_LSB = 17;
  localparam int MSI_MME_LSB = 20;
  localparam int MSI_64_BIT = 23;
  localparam logic [2:0] MSI_MMC_VAL = 3'h0;
  localparam logic [2:0] MSI_MME_MAX = 3'h5;
  localparam logic [2:0] MSI_MME_RST = 3'h0;
  localparam int MSI_ALO_LSB = 2;
  localparam int MSI_DAT_W = 16;

  // error-reporting extended capability header
  localparam logic [15:0] AER_ID = 16'h0001;
  localparam logic [3:0] AER_VER = 4'h1;
  localparam logic [11:0] AER_NEXT = 12'h150;

  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  // one configuration access from the host
  typedef struct packed {
    logic wr;
    logic [11:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } pcr_cfg_req_s;

  // one message write toward the host
  typedef struct packed {
    logic [63:0] addr;
    logic [MSI_DAT_W-1:0] data;
  } pcr_msg_s;

  // eeprom access request
  typedef struct packed {
    logic we;
    logic [7:0] addr;
    logic [31:0] wdata;
  } pcr_ee_req_s;

  typedef enum logic [0:0] {
    EE_IDLE,
    EE_WAIT
  } pcr_ee_state_e;

endpackage

// ===== tb/pcr_cfg_regs_properties.sv
// timing and relation checks on the config register block ports
`timescale 1ns/1ps
module pcr_cfg_regs_properties (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic cfg_req_i,
  input wire pcr_pkg::pcr_cfg_req_s cfg_i,
  input wire logic cfg_ack_o,
  input wire logic [31:0] cfg_rdata_o,
  input wire logic irq_i,
  input wire logic intx_o,
  input wire logic msg_vld_o,
  input wire pcr_pkg::pcr_msg_s msg_o,
  input wire logic msg_ack_i,
  input wire logic ee_req_o,
  input wire pcr_pkg::pcr_ee_req_s ee_cmd_o,
  input wire logic ee_ack_i,
  input wire logic [31:0] ee_rdata_i
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);
  ////////////////////////////////////////
  ack_follows_req_a: assert property (
    ce_i && cfg_req_i |=> cfg_ack_o) else $error("ack missing");
  ack_has_cause_a: assert property (
    cfg_ack_o |-> $past(cfg_req_i)) else $error("ack without request");
  read_lane_mask_a: assert property (
    cfg_ack_o && !$past(cfg_i.wr) && !$past(cfg_i.be[3])
    |-> cfg_rdata_o[31:24] == 8'h0) else $error("masked lane not zero");
  intx_has_cause_a: assert property (
    intx_o |-> $past(irq_i)) else $error("legacy pin without request");
  msg_not_intx_a: assert property (
    msg_vld_o |-> !intx_o) else $error("message and legacy pin together");
  msg_on_rise_a: assert property (
    $rose(msg_vld_o) |-> $past(irq_i) && !$past(irq_i, 2))
    else $error("message without rising request");
  msg_held_a: assert property (
    msg_vld_o && !msg_ack_i |=> msg_vld_o && $stable(msg_o))
    else $error("message dropped before accept");
  msg_addr_align_a: assert property (
    msg_vld_o |-> msg_o.addr[1:0] == 2'b00) else $error("address unaligned");
  ee_req_held_a: assert property (
    ee_req_o && !ee_ack_i |=> ee_req_o && $stable(ee_cmd_o))
    else $error("eeprom request dropped");
  ee_req_drop_a: assert property (
    ee_req_o && ee_ack_i |=> !ee_req_o) else $error("eeprom request stuck");
  ee_start_a: assert property (
    $rose(ee_req_o) |-> $past(cfg_req_i && cfg_i.wr && cfg_i.be[3]
    && cfg_i.addr == 12'h0d8)) else $error("eeprom start without write");
endmodule
bind pcr_cfg_regs pcr_cfg_regs_properties i_pcr_cfg_regs_properties (
  .clk_i, .rst_b_i, .ce_i, .cfg_req_i, .cfg_i, .cfg_ack_o, .cfg_rdata_o,
  .irq_i, .intx_o, .msg_vld_o, .msg_o, .msg_ack_i, .ee_req_o, .ee_cmd_o,
  .ee_ack_i, .ee_rdata_i);

// ===== tb/pcr_ee_model.sv
// eeprom and message sink model facing the config register block
`timescale 1ns/1ps
module pcr_ee_model (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [3:0] lat_i,
  input wire logic ee_req_i,
  input wire pcr_pkg::pcr_ee_req_s ee_cmd_i,
  output logic ee_ack_o,
  output logic [31:0] ee_rdata_o,
  input wire logic msg_vld_i,
  output logic msg_ack_o
);
  logic [7:0] mem [256];
  logic [3:0] cnt_q;
  initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5a;
  ////////////////////////////////////////
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_q <= 4'h0;
      ee_ack_o <= 1'b0;
      ee_rdata_o <= 32'h0;
    end else begin
      ee_ack_o <= 1'b0;
      ee_rdata_o <= ~ee_rdata_o;
      if (ee_req_i && !ee_ack_o) begin
        cnt_q <= cnt_q + 4'h1;
        if (cnt_q >= lat_i) begin
          cnt_q <= 4'h0;
          ee_ack_o <= 1'b1;
          for (int i = 0; i < 4; i++) begin // lane i is byte addr+i
            if (ee_cmd_i.we)
              mem[ee_cmd_i.addr + 8'(i)] <= ee_cmd_i.wdata[8*i+:8];
            else
              ee_rdata_o[8*i+:8] <= mem[ee_cmd_i.addr + 8'(i)];
          end
        end
      end
    end
  end
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) msg_ack_o <= 1'b0;
    else msg_ack_o <= msg_vld_i && !msg_ack_o;
  end
endmodule

// ===== tb/test_pcr_cfg_regs.sv
// self-checking bench for the config capability register block
`timescale 1ns/1ps
module test_pcr_cfg_regs;
  logic clk_i, rst_b_i, ce_i, cfg_req_i, irq_i, cfg_ack_o, intx_o;
  logic msg_vld_o, msg_ack_i, ee_req_o, ee_ack_i;
  logic [31:0] cfg_rdata_o, ee_rdata_i, r, e, d;
  logic [3:0] lat, be;
  logic [11:0] a;
  pcr_pkg::pcr_cfg_req_s cfg_i;
  pcr_pkg::pcr_msg_s msg_o;
  pcr_pkg::pcr_ee_req_s ee_cmd_o;
  int fails, checked, cyc, n;
  logic [31:0] m [4096];
  logic [11:0] adr [8] = '{12'h0dc, 12'h0e0, 12'h0f0, 12'h0f4, 12'h0f8,
                           12'h0fc, 12'h100, 12'h0e8};
  pcr_cfg_regs i_pcr_cfg_regs (.clk_i, .rst_b_i, .ce_i, .cfg_req_i, .cfg_i,
    .cfg_ack_o, .cfg_rdata_o, .irq_i, .intx_o, .msg_vld_o, .msg_o,
    .msg_ack_i, .ee_req_o, .ee_cmd_o, .ee_ack_i, .ee_rdata_i);
  pcr_ee_model i_pcr_ee_model (.clk_i, .rst_b_i, .lat_i(lat),
    .ee_req_i(ee_req_o), .ee_cmd_i(ee_cmd_o), .ee_ack_o(ee_ack_i),
    .ee_rdata_o(ee_rdata_i), .msg_vld_i(msg_vld_o), .msg_ack_o(msg_ack_i));
  ////////////////////////////////////////
  function automatic logic [31:0] fx(input logic [11:0] x);
    case (x)
      12'h0d8: return 32'h0000_f003;
      12'h0f0: return 32'h0080_0005;
      12'h100: return 32'h1501_0001;
      default: return 32'h0;
    endcase
  endfunction
  function automatic logic [31:0] wm(input logic [11:0] x);
    case (x)
      12'h0dc, 12'h0f8: return 32'hffff_ffff;
      12'h0e0: return 32'h0000_0fff;
      12'h0f0: return 32'h0071_0000;
      12'h0f4: return 32'hffff_fffc;
      12'h0fc: return 32'h0000_ffff;
      default: return 32'h0;
    endcase
  endfunction
  function automatic logic [31:0] bm(input logic [3:0] b);
    return {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
  endfunction
  function automatic logic [11:0] tg(input logic [11:0] x);
    return (x == 12'h0e4) ? {m[12'h0e0][11:2], 2'b00} : x;
  endfunction
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    checked++;
    if (s !== x) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, x);
    end
  endtask
  task automatic acc(input logic w, input logic [11:0] x,
                     input logic [3:0] b, input logic [31:0] v);
    cfg_req_i <= 1'b1;
    cfg_i <= '{wr: w, addr: x, be: b, wdata: v};
    @(posedge clk_i);
    cfg_req_i <= 1'b0;
    #1 r = cfg_rdata_o;
    chk({31'h0, cfg_ack_o}, 32'h1);
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [11:0] x, input logic [3:0] b,
                    input logic [31:0] v);
    logic [31:0] k;
    logic [11:0] t;
    t = tg(x);
    k = wm(t) & bm(b);
    if (t == 12'h0f0 && v[22:20] > 3'h5) k[22:20] = 3'h0;
    m[t] = (m[t] & ~k) | (v & k);
    acc(1'b1, x, b, v);
  endtask
  task automatic rd(input logic [11:0] x, input logic [3:0] b);
    e = (m[tg(x)] | fx(tg(x))) & bm(b);
    acc(1'b0, x, b, 32'h0);
  endtask
  task automatic poll(input logic v);
    n = 0;
    do begin
      rd(12'h0d8, 4'hf);
      n++;
    end while (r[31] !== v && n < 40);
  endtask
  task automatic close_out();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      close_out();
    end
  end
  initial begin
    rst_b_i = 1'b0;
    ce_i = 1'b1;
    cfg_req_i = 1'b0;
    cfg_i = '0;
    irq_i = 1'b0;
    lat = 4'h0;
    foreach (m[i]) m[i] = 32'h0;
    r = $urandom(32'hcba7);
    repeat (10) @(posedge clk_i);
    rst_b_i <= 1'b1;
    @(posedge clk_i);
    // reset values and fixed fields
    foreach (adr[i]) begin
      rd(adr[i], 4'hf);
      chk(r, e);
    end
    rd(12'h0d8, 4'hf);
    chk(r[15:0], 32'hf003);
    // random partial writes
    repeat (60) begin
      a = adr[$urandom_range(7, 0)];
      be = 4'($urandom);
      d = $urandom;
      wr(a, be, d);
      rd(a, 4'($urandom));
      chk(r, e);
    end
    for (int c = 0; c < 8; c++) begin
      wr(12'h0f0, 4'h4, {9'h0, 3'(c), 20'h0});
      rd(12'h0f0, 4'hf);
      chk(r, e);
    end
    wr(12'h0f0, 4'hf, 32'h0);
    // indirect window
    wr(12'h0e0, 4'hf, 32'h0000_00f8);
    wr(12'h0e4, 4'hf, 32'h1234_5678);
    rd(12'h0f8, 4'hf);
    chk(r, e);
    rd(12'h0e4, 4'h3);
    chk(r, e);
    // clock enable low freezes the block
    ce_i <= 1'b0;
    cfg_req_i <= 1'b1;
    cfg_i <= '{wr: 1'b1, addr: 12'h0f8, be: 4'hf, wdata: 32'h0};
    repeat (3) @(posedge clk_i);
    ce_i <= 1'b1;
    cfg_req_i <= 1'b0;
    #1 chk({31'h0, cfg_ack_o}, 32'h0);
    @(posedge clk_i);
    rd(12'h0f8, 4'hf);
    chk(r, e);
    // eeprom read, fast answer
    acc(1'b1, 12'h0d8, 4'hc, {1'b0, 7'h0, 6'h2b, 18'h0});
    #1 chk(ee_cmd_o.addr, 32'hec);
    @(posedge clk_i);
    poll(1'b1);
    chk(r, 32'h80ac_f003);
    for (int j = 0; j < 4; j++) e[8*j+:8] = (8'hec + 8'(j)) ^ 8'h5a;
    m[12'h0dc] = e;
    rd(12'h0dc, 4'hf);
    chk(r, e);
    // eeprom write, slow answer
    wr(12'h0dc, 4'hf, 32'hcafe_f00d);
    lat <= 4'h8;
    acc(1'b1, 12'h0d8, 4'hc, {1'b1, 7'h0, 6'h11, 18'h0});
    rd(12'h0d8, 4'hf);
    chk(r[31], 32'h1);
    poll(1'b0);
    chk(r, 32'h0044_f003);
    chk({i_pcr_ee_model.mem[8'h87], i_pcr_ee_model.mem[8'h86],
         i_pcr_ee_model.mem[8'h85], i_pcr_ee_model.mem[8'h84]},
        32'hcafe_f00d);
    // legacy pin, then message
    irq_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    #1 chk({intx_o, msg_vld_o}, 32'h2);
    @(posedge clk_i);
    irq_i <= 1'b0;
    wr(12'h0f4, 4'hf, 32'h1234_567b);
    wr(12'h0f8, 4'hf, 32'h89ab_cdef);
    wr(12'h0fc, 4'hf, 32'hffff_a55a);
    wr(12'h0f0, 4'h4, 32'h0001_0000);
    irq_i <= 1'b1;
    n = 0;
    while (msg_vld_o !== 1'b1 && n < 10) begin
      @(posedge clk_i);
      #1 n++;
    end
    chk({31'h0, msg_vld_o}, 32'h1);
    chk(msg_o.addr[63:32], 32'h89ab_cdef);
    chk(msg_o.addr[31:0], 32'h1234_5678);
    chk({16'h0, msg_o.data}, 32'ha55a);
    chk({31'h0, intx_o}, 32'h0);
    @(posedge clk_i);
    irq_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    #1 chk({31'h0, msg_vld_o}, 32'h0);
    close_out();
  end
endmodule
